// ==== pkg/sbc_defs.vh ====
// Constants of the system-bus command/identifier controller: register
// offsets, field positions, reset values and the nine-bit word encodings.
// Assumes it is included by bare name from the design file.
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define SBC_OFF_CMD      8'h00
`define SBC_OFF_ADDR     8'h04
`define SBC_OFF_WDATA    8'h08
`define SBC_OFF_RDATA    8'h0C
`define SBC_OFF_STATUS   8'h10
`define SBC_OFF_RXWORD   8'h14
`define SBC_OFF_INDEP    8'h18

// ----------------------------------------------------------------------
// Order register fields
// ----------------------------------------------------------------------
`define SBC_OP_LSB       0
`define SBC_OP_MSB       1
`define SBC_SIZE_LSB     2
`define SBC_SIZE_MSB     3
`define SBC_NOCHK_BIT    4
`define SBC_OP_WRITE     2'h0
`define SBC_OP_READ      2'h1
`define SBC_OP_INDEP     2'h2
`define SBC_OP_RELEASE   2'h3

// Status register fields
`define SBC_ST_BUSY      0
`define SBC_ST_OWNED     1
`define SBC_ST_RDDONE    2
`define SBC_ST_RDERR     3
`define SBC_ST_PROTERR   4
`define SBC_ST_DEVREQ    5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SBC_RST_WORD     32'h0000_0000
`define SBC_RST_INDEP    16'h0010

// ----------------------------------------------------------------------
// Nine-bit command / data identifier layout
// ----------------------------------------------------------------------
`define SBC_KIND_BIT     8
`define SBC_TYPE_MSB     7
`define SBC_TYPE_LSB     5
`define SBC_ATTR_MSB     4
`define SBC_ATTR_LSB     3
`define SBC_RETAIN_BIT   2
`define SBC_ID_LAST_BIT  7
`define SBC_ID_RESP_BIT  6
`define SBC_ID_ERR_BIT   5
`define SBC_ID_CHK_BIT   4
`define SBC_TYPE_READ    3'h0
`define SBC_TYPE_WRITE   3'h2
`define SBC_TYPE_NULL    3'h3
`define SBC_ATTR_BLOCK   2'h2
`define SBC_ATTR_WORD    2'h3
`define SBC_ATTR_RELEASE 2'h0
`define SBC_BSIZE_2W     2'h0
`define SBC_BSIZE_8W     2'h1

`endif

// ==== verilog/sbc_ctrl.v ====
// External-agent controller for the processor's multiplexed system bus.
// Assumes an APB master on pclk and the processor pins on the far side;
// every pin input is asynchronous to pclk and is synchronised here.
//
// Overview of operation
// - Valid strobe stays high during independent transfer
// - Release null command returns interface afterwards
// - Bit eight: zero command, one identifier
// - Type bits: read, write, null; others reserved
// - Read attribute: block or partial word
// - Block read size: two or eight words
// - Partial read: one to four valid bytes
// - Write attribute: block or partial word
// - Block write size, eight-word retain bit
// - Partial write: one to four valid bytes
// - Null attribute zero means interface release
// - Identifier bit seven: zero marks last
// - Identifier bit six: zero marks response
// - Block responses deliver whole line despite errors
// - Agent ignores error bit from processor
// - Identifier bit four: skip data checking
// - Agent decoding ignores processor reserved bits
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_ctrl (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [31:0] muxed_addr_data_bus_in,
	output reg  [31:0] muxed_addr_data_bus_out,
	output reg         muxed_addr_data_bus_oe,
	input  wire [8:0]  cmd_ident_bus_in,
	output reg  [8:0]  cmd_ident_bus_out,
	output reg         cmd_ident_bus_oe,
	output reg         ext_valid_strobe_n,
	output reg         ext_req_n,
	input  wire        proc_valid_strobe_n,
	input  wire        proc_release_n
);

	// ------------------------------------------------------------------
	// States
	// ------------------------------------------------------------------
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_REQ   = 3'h1;
	localparam [2:0] ST_ADDR  = 3'h2;
	localparam [2:0] ST_DATA  = 3'h3;
	localparam [2:0] ST_RWAIT = 3'h4;
	localparam [2:0] ST_INDEP = 3'h5;
	localparam [2:0] ST_NULL  = 3'h6;
	localparam [2:0] ST_DONE  = 3'h7;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// True when a command word uses a reserved type, attribute or size
	function cmd_reserved;
		input [8:0] w;
		begin
			cmd_reserved = 1'b0;
			case (w[`SBC_TYPE_MSB:`SBC_TYPE_LSB])
				`SBC_TYPE_READ, `SBC_TYPE_WRITE: begin
					if (w[`SBC_ATTR_MSB] == 1'b0)
						cmd_reserved = 1'b1;
					else if (w[`SBC_ATTR_MSB:`SBC_ATTR_LSB] == `SBC_ATTR_BLOCK &&
					         w[1] == 1'b1)
						cmd_reserved = 1'b1;
				end
				`SBC_TYPE_NULL: begin
					if (w[`SBC_ATTR_MSB:`SBC_ATTR_LSB] != `SBC_ATTR_RELEASE)
						cmd_reserved = 1'b1;
				end
				default: cmd_reserved = 1'b1;
			endcase
		end
	endfunction
	// Builds an outgoing data identifier; reserved bits driven zero
	function [8:0] mk_ident;
		input last_n;
		input not_resp;
		input nochk;
		begin
			mk_ident = 9'h000;
			mk_ident[`SBC_KIND_BIT]    = 1'b1;
			mk_ident[`SBC_ID_LAST_BIT] = last_n;
			mk_ident[`SBC_ID_RESP_BIT] = not_resp;
			mk_ident[`SBC_ID_CHK_BIT]  = nochk;
		end
	endfunction
	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	reg [31:0] bus_s1_reg;     // First stage, read only by the second
	reg [31:0] bus_s2_reg;     // Settled data bus
	reg [8:0]  cmd_s1_reg;     // First stage
	reg [8:0]  cmd_s2_reg;     // Settled command bus
	reg [1:0]  vld_s1_reg;     // First stage of strobe and release
	reg [1:0]  vld_s2_reg;     // Settled strobe (bit 0) and release (bit 1)
	// Two flops on every pin before any logic looks at it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_s1_reg <= 32'h0000_0000;
			bus_s2_reg <= 32'h0000_0000;
			cmd_s1_reg <= 9'h000;
			cmd_s2_reg <= 9'h000;
			vld_s1_reg <= 2'h3;
			vld_s2_reg <= 2'h3;
		end else begin
			bus_s1_reg <= muxed_addr_data_bus_in;
			bus_s2_reg <= bus_s1_reg;
			cmd_s1_reg <= cmd_ident_bus_in;
			cmd_s2_reg <= cmd_s1_reg;
			vld_s1_reg <= {proc_release_n, proc_valid_strobe_n};
			vld_s2_reg <= vld_s1_reg;
		end
	end

	wire proc_vld = ~vld_s2_reg[0];   // Processor drives a valid word
	wire released = ~vld_s2_reg[1];   // Processor has gone to slave state
	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	reg [31:0] addr_reg;       // Address for the external request
	reg [31:0] wdata_reg;      // Data for an external write
	reg [31:0] rdata_reg;      // Last word returned by the processor
	reg [8:0]  rxword_reg;     // Last word the processor drove
	reg [15:0] indep_reg;      // Cycles reserved for a third-party transfer
	reg [4:0]  order_reg;      // Latched order: op, size, no-check
	reg        rddone_reg;     // Sticky: read answer arrived
	reg        rderr_reg;      // Sticky: read answer carried the error bit
	reg        proterr_reg;    // Sticky: reserved encoding seen
	reg        devreq_reg;     // Sticky: processor issued its own request
	reg [2:0]  state_reg;      // Sequencer state
	reg [15:0] cnt_reg;        // Independent-transfer counter
	wire wr_en  = psel & penable & pwrite;
	wire go     = wr_en && paddr == `SBC_OFF_CMD && state_reg == ST_IDLE;
	wire w1c    = wr_en && paddr == `SBC_OFF_STATUS;
	wire mapped = paddr == `SBC_OFF_CMD   || paddr == `SBC_OFF_ADDR   ||
	              paddr == `SBC_OFF_WDATA || paddr == `SBC_OFF_RDATA  ||
	              paddr == `SBC_OFF_STATUS|| paddr == `SBC_OFF_RXWORD ||
	              paddr == `SBC_OFF_INDEP;
	// Zero-wait slave; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	// Read mux: flops selected combinationally during the access phase
	always @* begin
		case (paddr)
			`SBC_OFF_CMD:    prdata = {27'h0, order_reg};
			`SBC_OFF_ADDR:   prdata = addr_reg;
			`SBC_OFF_WDATA:  prdata = wdata_reg;
			`SBC_OFF_RDATA:  prdata = rdata_reg;
			`SBC_OFF_STATUS: prdata = {26'h0, devreq_reg, proterr_reg, rderr_reg,
			                           rddone_reg, ~ext_req_n & released,
			                           state_reg != ST_IDLE};
			`SBC_OFF_RXWORD: prdata = {23'h0, rxword_reg};
			`SBC_OFF_INDEP:  prdata = {16'h0, indep_reg};
			default:         prdata = 32'h0000_0000;
		endcase
	end
	// Plain configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg  <= `SBC_RST_WORD;
			wdata_reg <= `SBC_RST_WORD;
			indep_reg <= `SBC_RST_INDEP;
			order_reg <= 5'h00;
		end else begin
			if (wr_en && paddr == `SBC_OFF_ADDR)
				addr_reg <= pwdata;
			if (wr_en && paddr == `SBC_OFF_WDATA)
				wdata_reg <= pwdata;
			if (wr_en && paddr == `SBC_OFF_INDEP)
				indep_reg <= pwdata[15:0];
			if (go)
				order_reg <= pwdata[4:0];
		end
	end

	// ------------------------------------------------------------------
	// Monitor of words the processor drives
	// ------------------------------------------------------------------
	wire rx_cmd   = proc_vld & ~cmd_s2_reg[`SBC_KIND_BIT];
	wire rx_ident = proc_vld &  cmd_s2_reg[`SBC_KIND_BIT];
	wire rx_ans   = rx_ident && state_reg == ST_RWAIT;
	// Only real fields are looked at; reserved bits never steer logic
	wire rx_bad   = rx_cmd && cmd_reserved(cmd_s2_reg);
	// Sticky flags: a new event wins over a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg   <= `SBC_RST_WORD;
			rxword_reg  <= 9'h000;
			rddone_reg  <= 1'b0;
			rderr_reg   <= 1'b0;
			proterr_reg <= 1'b0;
			devreq_reg  <= 1'b0;
		end else begin
			if (proc_vld)
				rxword_reg <= cmd_s2_reg;
			if (rx_ans)
				rdata_reg <= bus_s2_reg;
			if (rx_ans && !cmd_s2_reg[`SBC_ID_LAST_BIT])
				rddone_reg <= 1'b1;
			else if (w1c && pwdata[`SBC_ST_RDDONE])
				rddone_reg <= 1'b0;
			// Error bit of a read answer is expected set and only logged
			if (rx_ans && cmd_s2_reg[`SBC_ID_ERR_BIT])
				rderr_reg <= 1'b1;
			else if (w1c && pwdata[`SBC_ST_RDERR])
				rderr_reg <= 1'b0;
			if (rx_bad)
				proterr_reg <= 1'b1;
			else if (w1c && pwdata[`SBC_ST_PROTERR])
				proterr_reg <= 1'b0;
			if (rx_cmd && !rx_bad)
				devreq_reg <= 1'b1;
			else if (w1c && pwdata[`SBC_ST_DEVREQ])
				devreq_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// External request sequencer
	// ------------------------------------------------------------------
	wire [1:0] op   = order_reg[`SBC_OP_MSB:`SBC_OP_LSB];
	wire [1:0] size = order_reg[`SBC_SIZE_MSB:`SBC_SIZE_LSB];
	// Pins and state advance together; outputs come from flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg               <= ST_IDLE;
			cnt_reg                 <= 16'h0000;
			ext_req_n               <= 1'b1;
			ext_valid_strobe_n      <= 1'b1;
			muxed_addr_data_bus_out <= 32'h0000_0000;
			muxed_addr_data_bus_oe  <= 1'b0;
			cmd_ident_bus_out       <= 9'h000;
			cmd_ident_bus_oe        <= 1'b0;
		end else begin
			ext_valid_strobe_n <= 1'b1;
			case (state_reg)
				ST_IDLE: begin
					if (go) begin
						ext_req_n <= 1'b0;
						state_reg <= ST_REQ;
					end
				end
				ST_REQ: begin
					// Processor needs two cycles to see the request, then
					// finishes its own cycles; wait for its release
					if (released) begin
						muxed_addr_data_bus_oe <= 1'b1;
						cmd_ident_bus_oe       <= 1'b1;
						if (op == `SBC_OP_INDEP) begin
							muxed_addr_data_bus_oe <= 1'b0;
							cmd_ident_bus_oe       <= 1'b0;
							cnt_reg                <= indep_reg;
							state_reg              <= ST_INDEP;
						end else if (op == `SBC_OP_RELEASE) begin
							state_reg <= ST_NULL;
						end else begin
							muxed_addr_data_bus_out <= addr_reg;
							cmd_ident_bus_out <= {1'b0,
								(op == `SBC_OP_WRITE) ? `SBC_TYPE_WRITE
								                      : `SBC_TYPE_READ,
								`SBC_ATTR_WORD, 1'b0, size};
							ext_valid_strobe_n <= 1'b0;
							state_reg          <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (op == `SBC_OP_WRITE) begin
						// Single word: last element, not response data
						muxed_addr_data_bus_out <= wdata_reg;
						cmd_ident_bus_out  <= mk_ident(1'b0, 1'b1,
						                               order_reg[`SBC_NOCHK_BIT]);
						ext_valid_strobe_n <= 1'b0;
						state_reg          <= ST_DATA;
					end else begin
						// Hand the wires over so the processor can answer
						muxed_addr_data_bus_oe <= 1'b0;
						cmd_ident_bus_oe       <= 1'b0;
						state_reg              <= ST_RWAIT;
					end
				end
				ST_DATA: begin
					muxed_addr_data_bus_oe <= 1'b0;
					cmd_ident_bus_oe       <= 1'b0;
					state_reg              <= ST_DONE;
				end
				ST_RWAIT: begin
					if (rx_ans && !cmd_s2_reg[`SBC_ID_LAST_BIT])
						state_reg <= ST_DONE;
				end
				ST_INDEP: begin
					// Third parties own the wires; strobe held inactive
					ext_valid_strobe_n <= 1'b1;
					if (cnt_reg == 16'h0000) begin
						muxed_addr_data_bus_oe <= 1'b1;
						cmd_ident_bus_oe       <= 1'b1;
						state_reg              <= ST_NULL;
					end else begin
						cnt_reg <= cnt_reg - 16'h0001;
					end
				end
				ST_NULL: begin
					// Null command with the interface-release attribute
					muxed_addr_data_bus_out <= 32'h0000_0000;
					cmd_ident_bus_out  <= {1'b0, `SBC_TYPE_NULL,
					                       `SBC_ATTR_RELEASE, 3'h0};
					ext_valid_strobe_n <= 1'b0;
					state_reg          <= ST_DATA;
				end
				ST_DONE: begin
					// Give the bus back; processor resumes as master
					ext_req_n <= 1'b1;
					if (!released)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== verif/sbc_ctrl_asserts.sv ====
// Checker for sbc_ctrl: APB and pin-side relations over time.
// Assumes it is bound to sbc_ctrl and sees its ports by name.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_ctrl_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        muxed_addr_data_bus_oe,
	input wire logic [8:0]  cmd_ident_bus_out,
	input wire logic        cmd_ident_bus_oe,
	input wire logic        ext_valid_strobe_n,
	input wire logic        ext_req_n,
	input wire logic        proc_release_n
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	wire       acc = psel && penable;        // APB access phase
	wire       stb = !ext_valid_strobe_n;    // Our word strobe
	wire       cmd = stb && !cmd_ident_bus_out[8];
	wire [2:0] typ = cmd_ident_bus_out[7:5];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Every mapped word answers at once and without an error
	a_apb_zero_wait: assert property (acc && paddr <= `SBC_OFF_INDEP && paddr[1:0] == 2'h0
		|-> pready && !pslverr) else $error("mapped access stalled or refused");
	// Reads of holes return zero so software never sees stale data
	a_unmapped_err: assert property (acc && paddr > `SBC_OFF_INDEP |-> pslverr
		&& (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	a_reset_quiet: assert property ($rose(presetn) |-> ext_req_n && ext_valid_strobe_n
		&& !cmd_ident_bus_oe && !muxed_addr_data_bus_oe) else $error("pins active at reset");
	a_req_from_cmd: assert property ($fell(ext_req_n) |->
		$past(acc && pwrite && paddr == `SBC_OFF_CMD)) else $error("request without order");
	a_drive_after_rel: assert property ($rose(cmd_ident_bus_oe) |->
		!ext_req_n && $past(!proc_release_n, 2)) else $error("drove before release");
	a_strobe_driven: assert property (stb |-> cmd_ident_bus_oe
		&& muxed_addr_data_bus_oe && !ext_req_n && !proc_release_n)
		else $error("strobe without owning the bus");
	a_cmd_type: assert property (cmd |-> typ inside
		{`SBC_TYPE_READ, `SBC_TYPE_WRITE, `SBC_TYPE_NULL}) else $error("reserved type sent");
	a_cmd_attr: assert property (cmd |-> ((typ == `SBC_TYPE_NULL) ?
		cmd_ident_bus_out[4:0] == 5'h0 : (cmd_ident_bus_out[4:3] == `SBC_ATTR_WORD
		&& !cmd_ident_bus_out[2]))) else $error("bad attribute field");
	a_write_then_data: assert property (cmd && typ == `SBC_TYPE_WRITE |=>
		stb && cmd_ident_bus_out[8:5] == 4'hA) else $error("write data cycle missing");
	a_ident_clean: assert property (stb && cmd_ident_bus_out[8] |->
		cmd_ident_bus_out[5] == 1'b0 && cmd_ident_bus_out[3:0] == 4'h0)
		else $error("identifier reserved bits set");
	a_null_single: assert property (stb && cmd_ident_bus_out == 9'h060 |=>
		ext_valid_strobe_n ##[0:2] !cmd_ident_bus_oe) else $error("bus held after null");
	a_req_ends_quiet: assert property ($rose(ext_req_n) |-> !cmd_ident_bus_oe
		&& !muxed_addr_data_bus_oe && ext_valid_strobe_n) else $error("dropped request early");
	// Main scenarios seen
	c_write: cover property (cmd && typ == `SBC_TYPE_WRITE);
	c_read: cover property (cmd && typ == `SBC_TYPE_READ);
	c_null: cover property (stb && cmd_ident_bus_out == 9'h060);
endmodule
`default_nettype wire

// ==== verif/sbc_proc_model.sv ====
// Behavioural processor facing the controller's pins.
// Assumes the bench resolves shared lines and pclk is the bus clock.
`timescale 1ns/1ps
`default_nettype none
module sbc_proc_model #(
	parameter int REL_LAT = 2,  // Bus cycles still in progress at detection
	parameter int RD_LAT  = 2   // Cycles before a read is answered
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ext_req_n,
	input  wire logic        ext_valid_strobe_n,
	input  wire logic        cmd_ident_bus_oe,
	input  wire logic [8:0]  cmd_ident_bus_in,
	input  wire logic [31:0] muxed_addr_data_bus_in,
	output var  logic        proc_release_n,
	output var  logic        proc_valid_strobe_n,
	output var  logic        p_oe,
	output var  logic [8:0]  p_cmd,
	output var  logic [31:0] p_data
);
	logic [8:0]  last_cmd, last_ident, own_word;  // Captured words
	logic [31:0] last_addr, last_data;
	logic        own_go = 1'b0;                   // Own command pending
	int          req_cnt, rd_wait;
	int          n_cmd = 0, n_null = 0, n_stray = 0, n_err = 0;
	// ------------------------------------------------------------
	// Pin behaviour
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proc_release_n <= 1'b1;
			proc_valid_strobe_n <= 1'b1;
			p_oe <= 1'b0;
			req_cnt <= 0;
			rd_wait <= 0;
		end else begin
			p_oe <= 1'b0;
			proc_valid_strobe_n <= 1'b1;
			// Request seen two cycles on, released after work in hand
			req_cnt <= ext_req_n ? 0 : req_cnt + 1;
			if (ext_req_n)
				proc_release_n <= 1'b1;
			else if (req_cnt >= 1 + REL_LAT)
				proc_release_n <= 1'b0;
			if (rd_wait > 0)
				rd_wait <= rd_wait - 1;
			if (!ext_valid_strobe_n) begin
				// A strobe outside an owned, driven bus is stray traffic
				if (!cmd_ident_bus_oe || proc_release_n)
					n_stray <= n_stray + 1;
				if (!cmd_ident_bus_in[8]) begin
					last_cmd <= cmd_ident_bus_in;
					last_addr <= muxed_addr_data_bus_in;
					n_cmd <= n_cmd + 1;
					if (cmd_ident_bus_in[7:5] == 3'h0)
						rd_wait <= RD_LAT;
					if (cmd_ident_bus_in == 9'h060)
						n_null <= n_null + 1;
				end else begin
					last_ident <= cmd_ident_bus_in;
					last_data <= muxed_addr_data_bus_in;
					if (cmd_ident_bus_in[5])
						n_err <= n_err + 1;
				end
			end
			// Read answered with the inverted address as data, flagged erroneous
			if (rd_wait == 1) begin
				p_oe <= 1'b1;
				p_cmd <= 9'h120;
				p_data <= ~last_addr;
				proc_valid_strobe_n <= 1'b0;
			end else if (own_go && proc_release_n && ext_req_n) begin
				p_oe <= 1'b1;
				p_cmd <= own_word;
				p_data <= 32'h0;
				proc_valid_strobe_n <= 1'b0;
				own_go <= 1'b0;
			end
		end
	end
	// Queue one command word of our own, sent while in master state
	task automatic send(input logic [8:0] w);
		own_word <= w;
		own_go <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verif/sbc_ctrl_tb_top.sv ====
// Self-checking bench for sbc_ctrl with a processor model.
// Assumes sbc_defs.vh is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_ctrl_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic        sl_err;
	wire  [31:0] prdata, bus_in, bus_out, p_data;
	wire  [8:0]  cmd_in, cmd_out, p_cmd;
	wire         pready, pslverr, bus_oe, cmd_oe, stb_n, req_n, pstb_n, rel_n, p_oe;
	logic [31:0] junk = 32'h5A5A_5A5A;  // Undriven lines change every cycle
	int          error_cnt = 0, num_checks = 0;
	always #20 pclk = ~pclk;
	always @(posedge pclk) junk <= ~junk;
	assign bus_in = bus_oe ? bus_out : (p_oe ? p_data : junk);
	assign cmd_in = cmd_oe ? cmd_out : (p_oe ? p_cmd : junk[8:0]);
	sbc_ctrl sbc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
		.muxed_addr_data_bus_oe(bus_oe), .cmd_ident_bus_in(cmd_in), .cmd_ident_bus_out(cmd_out),
		.cmd_ident_bus_oe(cmd_oe), .ext_valid_strobe_n(stb_n), .ext_req_n(req_n),
		.proc_valid_strobe_n(pstb_n), .proc_release_n(rel_n));
	sbc_proc_model #(.REL_LAT(3), .RD_LAT(2)) sbc_proc_model_i (.pclk(pclk), .presetn(presetn),
		.ext_req_n(req_n), .ext_valid_strobe_n(stb_n), .cmd_ident_bus_oe(cmd_oe),
		.cmd_ident_bus_in(cmd_in), .muxed_addr_data_bus_in(bus_in), .proc_release_n(rel_n),
		.proc_valid_strobe_n(pstb_n), .p_oe(p_oe), .p_cmd(p_cmd), .p_data(p_data));
	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		sl_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Poll busy; the watchdog bounds a hang
	task automatic wait_idle;
		do apb(1'b0, `SBC_OFF_STATUS, 32'h0);
		while (rd[`SBC_ST_BUSY] !== 1'b0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, `SBC_OFF_STATUS, 32'h0);
		chk("status reset", `SBC_RST_WORD, rd);
		apb(1'b0, `SBC_OFF_INDEP, 32'h0);
		chk("indep reset", {16'h0, `SBC_RST_INDEP}, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, sl_err});
		apb(1'b1, `SBC_OFF_INDEP, 32'h2);  // Short window keeps the run brief
	endtask
	// Every valid-byte size; a second order while busy must be dropped
	task automatic t_write;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, `SBC_OFF_ADDR, 32'h1000_0000 + 4 * s);
			apb(1'b1, `SBC_OFF_WDATA, 32'hA5A5_0000 + s);
			apb(1'b1, `SBC_OFF_CMD, {27'h0, s[0], s[1:0], `SBC_OP_WRITE});
			apb(1'b1, `SBC_OFF_CMD, {30'h0, `SBC_OP_READ});
			wait_idle();
			chk("write cmd", 32'h58 + s, {23'h0, sbc_proc_model_i.last_cmd});
			chk("write addr", 32'h1000_0000 + 4 * s, sbc_proc_model_i.last_addr);
			chk("write data", 32'hA5A5_0000 + s, sbc_proc_model_i.last_data);
			chk("write ident", 32'h140 + (s % 2) * 16, {23'h0, sbc_proc_model_i.last_ident});
		end
		chk("order count", 32'h0000_0004, sbc_proc_model_i.n_cmd);
	endtask
	task automatic t_read;
		apb(1'b1, `SBC_OFF_ADDR, 32'h2000_0000);
		apb(1'b1, `SBC_OFF_CMD, {28'h0, 2'h3, `SBC_OP_READ});
		wait_idle();
		chk("read cmd", 32'h01B, {23'h0, sbc_proc_model_i.last_cmd});
		apb(1'b0, `SBC_OFF_RDATA, 32'h0);
		chk("read data", ~32'h2000_0000, rd);
		apb(1'b0, `SBC_OFF_STATUS, 32'h0);
		chk("read flags", 32'hC, rd & 32'hC);
		apb(1'b1, `SBC_OFF_STATUS, 32'hC);
		apb(1'b0, `SBC_OFF_STATUS, 32'h0);
		chk("flags cleared", 32'h0, rd & 32'hC);
	endtask
	task automatic t_indep;
		int q;
		q = sbc_proc_model_i.n_null;
		apb(1'b1, `SBC_OFF_CMD, {30'h0, `SBC_OP_INDEP});
		wait_idle();
		chk("null after window", q + 1, sbc_proc_model_i.n_null);
		chk("quiet window", 32'h0, sbc_proc_model_i.n_stray);
		chk("null word", 32'h060, {23'h0, sbc_proc_model_i.last_cmd});
		apb(1'b1, `SBC_OFF_CMD, {30'h0, `SBC_OP_RELEASE});
		wait_idle();
		chk("release null", q + 2, sbc_proc_model_i.n_null);
		chk("no error flag", 32'h0, sbc_proc_model_i.n_err);
	endtask
	// Processor commands: three legal, then reserved encodings
	task automatic t_devcmd;
		logic [8:0] w [8] = '{9'h01B, 9'h010, 9'h055, 9'h020, 9'h0A0, 9'h008, 9'h053, 9'h068};
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `SBC_OFF_STATUS, 32'h3C);
			sbc_proc_model_i.send(w[i]);
			repeat (6) @(posedge pclk);
			apb(1'b0, `SBC_OFF_STATUS, 32'h0);
			chk("decode flag", (i < 3) ? 32'h20 : 32'h10, rd & 32'h30);
			apb(1'b0, `SBC_OFF_RXWORD, 32'h0);
			chk("rx word", {23'h0, w[i]}, rd);
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_write();
		t_read();
		t_indep();
		t_devcmd();
		close_out();
	end
	initial begin
		#(20000 * 40);
		error_cnt++;
		close_out();
	end
endmodule
bind sbc_ctrl sbc_ctrl_asserts sbc_ctrl_asserts_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe),
	.cmd_ident_bus_out(cmd_ident_bus_out), .cmd_ident_bus_oe(cmd_ident_bus_oe),
	.ext_valid_strobe_n(ext_valid_strobe_n), .ext_req_n(ext_req_n),
	.proc_release_n(proc_release_n));
`default_nettype wire
